// ==== core/epm_counters.sv ====
// Receive performance monitoring counters, alarm latch and readback registers
//
// Functional notes
// - PRBS error count adds one per PRBS error detected.
// - PRBS multiframe count adds one per CRC multiframe; cleared on PRBS count write.
// - Alarm latch bit 7 sets on remote alarm; every latch bit clears on read.
// - Alarm latch bit 6 sets on all-ones alarm; clears on read.
// - Alarm latch bit 5 sets on timeslot 16 all-ones alarm; clears on read.
// - Alarm latch bit 4 sets on loss of signal; clears on read.
// - Alarm latch bit 3 sets on auxiliary pattern; clears on read.
// - Alarm latch bit 2 sets on multiframe alarm; clears on read.
// - Alarm latch bit 1 sets on elastic buffer slip; bit 0 unused.
// - Errored frame alignment count adds one per errored alignment signal.
// - E-bit count: upper bits in bits 1-0 of high register, low byte separate.
// - Sixteen-bit line code violation count, upper byte in its own register.
// - Excess-zeros control low: count only non-HDB3 bipolar violations.
// - Excess-zeros control high: count bipolar violations or excess zeros.
// - Sixteen-bit CRC-4 error count read as high and low byte.
// - Read-only register returns the 5-bit line peak converter value.
// - Read-only register returns the 8-bit equalized peak converter value.
// - Read-only identification register returns a fixed device code.
// - Event word zero bits rise on their condition change, clear on read.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module epm_counters
   import epm_pkg::*;
#(
   // Arbitrary neutral value, not a real part code
   parameter logic [7:0] DEVICE_CODE = 8'h5a
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Host register port
   input wire logic [7:0] page_i,
   input wire logic [4:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Error events from framer and line interface
   input wire logic prbs_err_i,
   input wire logic crc_mf_i,
   input wire logic fas_err_i,
   input wire logic ebit_err_i,
   input wire logic bipolar_viol_i,
   input wire logic excess_zeros_i,
   input wire logic crc_err_i,
   // Alarm conditions
   input wire logic remote_alarm_i,
   input wire logic all_ones_i,
   input wire logic ts16_all_ones_i,
   input wire logic signal_lost_i,
   input wire logic aux_pattern_i,
   input wire logic mf_alarm_i,
   input wire logic rx_slip_i,
   // Unmasked event pulses for the two event words
   input wire logic [7:0] evt0_i,
   input wire logic [7:0] evt1_i,
   // Peak detector converters
   input wire logic [4:0] line_peak_i,
   input wire logic [7:0] eq_peak_i,
   // Control out
   output logic excess_zeros_enable_o
);

   // Register state
   logic [7:0] prbs_err_cnt_q;
   logic [7:0] prbs_mf_cnt_q;
   logic [7:0] alarm_q;
   logic [7:0] alarm_d;
   logic [7:0] errored_fas_cnt_q;
   logic [9:0] ebit_cnt_q;
   logic [15:0] line_viol_cnt_q;
   logic [15:0] crc_err_cnt_q;
   logic [7:0] evt0_q;
   logic [7:0] evt1_q;
   logic [4:0] line_peak_value_q;
   logic [7:0] eq_peak_q;
   logic excess_zeros_enable_q;
   logic [7:0] rdata_q;
   logic [7:0] rmux;
   logic [7:0] alarm_set;

   // Page and address decode
   logic mon_sel;
   logic ana_sel;
   logic ctl_sel;
   logic wr_prbs;
   logic wr_ctrl;
   logic rd_alarm;
   logic rd_evt0;
   logic rd_evt1;
   logic line_viol;

   // Registers only answer inside their own page
   assign mon_sel = (page_i == EPM_PAGE_MON);
   assign ana_sel = (page_i == EPM_PAGE_ANALOG);
   assign ctl_sel = (page_i == EPM_PAGE_CTRL);
   assign wr_prbs = wr_i && mon_sel && (addr_i == EPM_A_PRBS_ERR);
   assign wr_ctrl = wr_i && ctl_sel && (addr_i == EPM_A_CTRL);
   assign rd_alarm = rd_i && mon_sel && (addr_i == EPM_A_ALARM);
   assign rd_evt0 = rd_i && mon_sel && (addr_i == EPM_A_EVT0);
   assign rd_evt1 = rd_i && mon_sel && (addr_i == EPM_A_EVT1);

   // Violation qualifier picks its definition from the control bit
   always_comb
   begin
      if (excess_zeros_enable_q)
      begin
         line_viol = bipolar_viol_i || excess_zeros_i;
      end
      else
      begin
         line_viol = bipolar_viol_i;
      end
   end

   // PRBS error count; a host write takes priority over a same-cycle error
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         prbs_err_cnt_q <= EPM_RST8;
      end
      else if (wr_prbs)
      begin
         prbs_err_cnt_q <= wdata_i;
      end
      else if (prbs_err_i)
      begin
         prbs_err_cnt_q <= prbs_err_cnt_q + EPM_ONE8;
      end
   end

   // Multiframe count; a multiframe arriving with the clearing write is kept
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         prbs_mf_cnt_q <= EPM_RST8;
      end
      else if (wr_prbs)
      begin
         prbs_mf_cnt_q <= crc_mf_i ? EPM_ONE8 : EPM_RST8;
      end
      else if (crc_mf_i)
      begin
         prbs_mf_cnt_q <= prbs_mf_cnt_q + EPM_ONE8;
      end
   end

   // Alarm set terms, bit 0 never sets
   always_comb
   begin
      alarm_set = EPM_RST8;
      alarm_set[EPM_B_REMOTE] = remote_alarm_i;
      alarm_set[EPM_B_ALL_ONES] = all_ones_i;
      alarm_set[EPM_B_TS16] = ts16_all_ones_i;
      alarm_set[EPM_B_LOST] = signal_lost_i;
      alarm_set[EPM_B_AUX] = aux_pattern_i;
      alarm_set[EPM_B_MF_ALARM] = mf_alarm_i;
      alarm_set[EPM_B_SLIP] = rx_slip_i;
   end

   // Read clears the latch, but a set in the same cycle survives it
   always_comb
   begin
      if (rd_alarm)
      begin
         alarm_d = alarm_set;
      end
      else
      begin
         alarm_d = alarm_q | alarm_set;
      end
   end

   // Alarm latch
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         alarm_q <= EPM_RST8;
      end
      else
      begin
         alarm_q <= alarm_d;
      end
   end

   // Errored frame alignment count, wraps at full scale
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         errored_fas_cnt_q <= EPM_RST8;
      end
      else if (fas_err_i)
      begin
         errored_fas_cnt_q <= errored_fas_cnt_q + EPM_ONE8;
      end
   end

   // E-bit count, ten bits wide
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         ebit_cnt_q <= EPM_RST10;
      end
      else if (ebit_err_i)
      begin
         ebit_cnt_q <= ebit_cnt_q + EPM_ONE10;
      end
   end

   // Line code violation count
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         line_viol_cnt_q <= EPM_RST16;
      end
      else if (line_viol)
      begin
         line_viol_cnt_q <= line_viol_cnt_q + EPM_ONE16;
      end
   end

   // CRC-4 error count
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         crc_err_cnt_q <= EPM_RST16;
      end
      else if (crc_err_i)
      begin
         crc_err_cnt_q <= crc_err_cnt_q + EPM_ONE16;
      end
   end

   // Event word zero, sticky until read, set beats clear
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         evt0_q <= EPM_RST8;
      end
      else if (rd_evt0)
      begin
         evt0_q <= evt0_i;
      end
      else
      begin
         evt0_q <= evt0_q | evt0_i;
      end
   end

   // Event word one, same behaviour as word zero
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         evt1_q <= EPM_RST8;
      end
      else if (rd_evt1)
      begin
         evt1_q <= evt1_i;
      end
      else
      begin
         evt1_q <= evt1_q | evt1_i;
      end
   end

   // Converter samples are retimed every cycle so reads see a stable word
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         line_peak_value_q <= EPM_RST8[EPM_LPEAK_W-1:0];
         eq_peak_q <= EPM_RST8;
      end
      else
      begin
         line_peak_value_q <= line_peak_i;
         eq_peak_q <= eq_peak_i;
      end
   end

   // Control register
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         excess_zeros_enable_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         excess_zeros_enable_q <= wdata_i[EPM_B_XZ_EN];
      end
   end

   // Read mux; high and low bytes are not snapshotted, so a carry between
   // the two reads can tear a 16-bit value
   always_comb
   begin
      rmux = EPM_RST8;
      if (mon_sel)
      begin
         case (addr_i)
            EPM_A_PRBS_ERR: rmux = prbs_err_cnt_q;
            EPM_A_PRBS_MF: rmux = prbs_mf_cnt_q;
            EPM_A_ALARM: rmux = alarm_q;
            EPM_A_EFAS: rmux = errored_fas_cnt_q;
            EPM_A_EBIT_HI: rmux = {6'h00, ebit_cnt_q[EPM_EBIT_W-1:8]};
            EPM_A_EBIT_LO: rmux = ebit_cnt_q[7:0];
            EPM_A_LCV_HI: rmux = line_viol_cnt_q[15:8];
            EPM_A_LCV_LO: rmux = line_viol_cnt_q[7:0];
            EPM_A_CRC_HI: rmux = crc_err_cnt_q[15:8];
            EPM_A_CRC_LO: rmux = crc_err_cnt_q[7:0];
            EPM_A_EVT0: rmux = evt0_q;
            EPM_A_EVT1: rmux = evt1_q;
            default: rmux = EPM_RST8;
         endcase
      end
      else if (ana_sel)
      begin
         case (addr_i)
            EPM_A_LPEAK: rmux = {3'h0, line_peak_value_q};
            EPM_A_EPEAK: rmux = eq_peak_q;
            EPM_A_ID: rmux = DEVICE_CODE;
            default: rmux = EPM_RST8;
         endcase
      end
      else if (ctl_sel && (addr_i == EPM_A_CTRL))
      begin
         rmux = {7'h00, excess_zeros_enable_q};
      end
   end

   // Read data stands for exactly one cycle after the strobe
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         rdata_q <= EPM_RST8;
      end
      else if (rd_i)
      begin
         rdata_q <= rmux;
      end
      else
      begin
         rdata_q <= EPM_RST8;
      end
   end

   // Outputs come straight from flops
   assign rdata_o = rdata_q;
   assign excess_zeros_enable_o = excess_zeros_enable_q;

endmodule : epm_counters

// ==== core/epm_pkg.sv ====
// Register map, field positions and reset values of the monitoring block
package epm_pkg;
   // Register pages
   localparam logic [7:0] EPM_PAGE_ANALOG = 8'h03;
   localparam logic [7:0] EPM_PAGE_MON = 8'h04;
   localparam logic [7:0] EPM_PAGE_CTRL = 8'h05;
   // Monitoring page addresses
   localparam logic [4:0] EPM_A_PRBS_ERR = 5'h10;
   localparam logic [4:0] EPM_A_PRBS_MF = 5'h11;
   localparam logic [4:0] EPM_A_ALARM = 5'h12;
   localparam logic [4:0] EPM_A_EFAS = 5'h13;
   localparam logic [4:0] EPM_A_EBIT_HI = 5'h14;
   localparam logic [4:0] EPM_A_EBIT_LO = 5'h15;
   localparam logic [4:0] EPM_A_LCV_HI = 5'h16;
   localparam logic [4:0] EPM_A_LCV_LO = 5'h17;
   localparam logic [4:0] EPM_A_CRC_HI = 5'h18;
   localparam logic [4:0] EPM_A_CRC_LO = 5'h19;
   localparam logic [4:0] EPM_A_EVT0 = 5'h1b;
   localparam logic [4:0] EPM_A_EVT1 = 5'h1c;
   // Analog page addresses
   localparam logic [4:0] EPM_A_LPEAK = 5'h1d;
   localparam logic [4:0] EPM_A_EPEAK = 5'h1e;
   localparam logic [4:0] EPM_A_ID = 5'h1f;
   // Control page address
   localparam logic [4:0] EPM_A_CTRL = 5'h10;
   // Alarm latch bit positions
   localparam int EPM_B_REMOTE = 7;
   localparam int EPM_B_ALL_ONES = 6;
   localparam int EPM_B_TS16 = 5;
   localparam int EPM_B_LOST = 4;
   localparam int EPM_B_AUX = 3;
   localparam int EPM_B_MF_ALARM = 2;
   localparam int EPM_B_SLIP = 1;
   // Control register bit positions
   localparam int EPM_B_XZ_EN = 0;
   // Field widths
   localparam int EPM_EBIT_W = 10;
   localparam int EPM_LPEAK_W = 5;
   // Reset values
   localparam logic [7:0] EPM_RST8 = 8'h00;
   localparam logic [9:0] EPM_RST10 = 10'h000;
   localparam logic [15:0] EPM_RST16 = 16'h0000;
   localparam logic [7:0] EPM_ONE8 = 8'h01;
   localparam logic [9:0] EPM_ONE10 = 10'h001;
   localparam logic [15:0] EPM_ONE16 = 16'h0001;
endpackage : epm_pkg

// ==== verification/epm_counters_properties.sv ====
// Concurrent checks on the host port of the monitoring counters
`timescale 1ns/100ps
module epm_counters_props
   import epm_pkg::*;
#(
   parameter logic [7:0] DEVICE_CODE = 8'h5a
)
(
   // Clock, reset and host port
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] page_i,
   input wire logic [4:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Watched events, converters and control
   input wire logic crc_mf_i,
   input wire logic remote_alarm_i,
   input wire logic [4:0] line_peak_i,
   input wire logic excess_zeros_enable_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Decoded strobes keep the properties short
   logic rd4, rd3, wr_ps;
   assign rd4 = rd_i && page_i == EPM_PAGE_MON;
   assign rd3 = rd_i && page_i == EPM_PAGE_ANALOG;
   assign wr_ps = wr_i && page_i == EPM_PAGE_MON && addr_i == EPM_A_PRBS_ERR;
   a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside answer");
   a_remote_alarm_set: assert property (
      remote_alarm_i ##1 (rd4 && addr_i == EPM_A_ALARM) |=> rdata_o[EPM_B_REMOTE])
      else $error("remote alarm not latched");
   // A set in the first read cycle survives, so only a quiet first read must clear
   a_alarm_read_clear: assert property (
      (rd4 && addr_i == EPM_A_ALARM && !remote_alarm_i) ##1 (rd4 && addr_i == EPM_A_ALARM)
      |=> !rdata_o[EPM_B_REMOTE]) else $error("alarm latch not cleared by read");
   a_alarm_bit0_zero: assert property (rd4 && addr_i == EPM_A_ALARM |=> !rdata_o[0])
      else $error("unused alarm bit set");
   a_ebit_high_pad: assert property (
      rd4 && addr_i == EPM_A_EBIT_HI |=> rdata_o[7:2] == 6'h00)
      else $error("ebit high byte padding");
   a_prbs_write_load: assert property (
      wr_ps ##1 (rd4 && addr_i == EPM_A_PRBS_ERR) |=> rdata_o == $past(wdata_i, 2))
      else $error("prbs count not loaded");
   a_mf_write_clear: assert property (
      (wr_ps && !crc_mf_i) ##1 (rd4 && addr_i == EPM_A_PRBS_MF) |=> rdata_o == 8'h00)
      else $error("mf count not cleared");
   a_unmapped_zero: assert property (rd4 && addr_i == 5'h1a |=> rdata_o == 8'h00)
      else $error("unused address not zero");
   a_line_peak_read: assert property (
      rd3 && addr_i == EPM_A_LPEAK && $stable(line_peak_i)
      |=> rdata_o == {3'h0, $past(line_peak_i)}) else $error("line peak wrong");
   a_id_read: assert property (rd3 && addr_i == EPM_A_ID |=> rdata_o == DEVICE_CODE)
      else $error("device code wrong");
   a_xz_enable_write: assert property (
      wr_i && page_i == EPM_PAGE_CTRL && addr_i == EPM_A_CTRL
      |=> excess_zeros_enable_o == $past(wdata_i[EPM_B_XZ_EN]))
      else $error("excess zeros enable not written");
   // Main scenarios
   c_alarm_twice: cover property (rd4 && addr_i == EPM_A_ALARM ##1 rd4);
   c_prbs_write: cover property (wr_ps ##1 rd4);
   c_id_read: cover property (rd3 && addr_i == EPM_A_ID);
endmodule : epm_counters_props

bind epm_counters epm_counters_props #(.DEVICE_CODE(DEVICE_CODE)) u_epm_counters_props (
   .clk_i(clk_i), .resetn_i(resetn_i), .page_i(page_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .crc_mf_i(crc_mf_i),
   .remote_alarm_i(remote_alarm_i), .line_peak_i(line_peak_i),
   .excess_zeros_enable_o(excess_zeros_enable_o));

// ==== verification/epm_host.sv ====
// Host processor model driving the paged register port
`timescale 1ns/100ps
module epm_host
(
   // Clock and host port
   input wire logic clk_i,
   output logic [7:0] page_o,
   output logic [4:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [7:0] rdata_i
);
   // Idle port at time zero
   initial {page_o, addr_o, wdata_o, wr_o, rd_o} = '0;
   // One-cycle write; callers never issue two writes back to back
   task automatic wr_reg(input logic [7:0] pg, input logic [4:0] a, input logic [7:0] d);
      page_o <= pg;
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
   endtask : wr_reg
   // One or two back-to-back reads; data taken mid-cycle, where it stands settled
   task automatic rd_reg(input logic [7:0] pg, input logic [4:0] a, input int n,
                         output logic [7:0] d0, output logic [7:0] d1);
      page_o <= pg;
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      if (n == 1) rd_o <= 1'b0;
      @(negedge clk_i);
      d0 = rdata_i;
      if (n == 2)
      begin
         @(posedge clk_i);
         rd_o <= 1'b0;
         @(negedge clk_i);
         d1 = rdata_i;
      end
      @(posedge clk_i);
   endtask : rd_reg
endmodule : epm_host

// ==== verification/epm_counters_tb.sv ====
// Self-checking bench for the monitoring counters
`timescale 1ns/100ps
module epm_counters_tb
   import epm_pkg::*;
;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary code
   logic clk_i, resetn_i, wr, rd, zen, ps, mf, fas, eb, bv, ez, ce;
   logic [7:0] page, wdata, rdata, evt0, evt1, eq_peak, d0, d1, e_alm, e_ps, e_mf, e_fas;
   logic [4:0] addr, line_peak;
   logic [6:0] alm;
   logic [9:0] e_eb;
   logic [15:0] e_lcv, e_crc;
   logic [31:0] r;
   int mismatches, n_tests;
   // Clock
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   epm_host u_epm_host (.clk_i(clk_i), .page_o(page), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
   epm_counters #(.DEVICE_CODE(ID)) u_epm_counters (.clk_i(clk_i), .resetn_i(resetn_i),
      .page_i(page), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .prbs_err_i(ps), .crc_mf_i(mf), .fas_err_i(fas), .ebit_err_i(eb), .bipolar_viol_i(bv),
      .excess_zeros_i(ez), .crc_err_i(ce), .remote_alarm_i(alm[6]), .all_ones_i(alm[5]),
      .ts16_all_ones_i(alm[4]), .signal_lost_i(alm[3]), .aux_pattern_i(alm[2]),
      .mf_alarm_i(alm[1]), .rx_slip_i(alm[0]), .evt0_i(evt0), .evt1_i(evt1),
      .line_peak_i(line_peak), .eq_peak_i(eq_peak), .excess_zeros_enable_o(zen));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task rchk(input logic [7:0] pg, input logic [4:0] a, input logic [7:0] exp);
      u_epm_host.rd_reg(pg, a, 1, d0, d1);
      chk(d0, exp);
   endtask : rchk
   task complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   // Excess zeros only count while enabled
   function logic lcv_hit(input logic v, input logic z, input logic x);
      return v || (x && z);
   endfunction : lcv_hit
   // Watchdog far beyond the fewer than a thousand cycles the run needs
   initial
   begin
      #100000;
      mismatches++;
      complete_run();
   end
   // Main sequence
   initial
   begin
      {resetn_i, ps, mf, fas, eb, bv, ez, ce, alm, evt0, evt1, line_peak, eq_peak} = '0;
      {e_alm, e_ps, e_mf, e_fas, e_eb, e_lcv, e_crc} = '0;
      void'($urandom(32'hd554));
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      for (int a = 16; a < 29; a++) rchk(EPM_PAGE_MON, 5'(a), 8'h00);
      $display("test reset values done");
      // Random events, both excess-zeros settings; the 8-bit counters wrap on purpose
      for (int m = 0; m < 2; m++)
      begin
         u_epm_host.wr_reg(EPM_PAGE_CTRL, EPM_A_CTRL, 8'(m));
         repeat (300)
         begin
            r = $urandom;
            // Bit 0 drives the PRBS error, bit 5 the CRC error, as the sums below expect
            {ce, bv, eb, fas, mf, ps} <= r[5:0];
            ez <= r[6] && !r[4];
            alm <= (r[15:12] == 4'h0) ? r[22:16] : 7'h00;
            e_alm = e_alm | ((r[15:12] == 4'h0) ? {r[22:16], 1'b0} : 8'h00);
            {e_ps, e_mf, e_fas, e_eb} = {e_ps + r[0], e_mf + r[1], e_fas + r[2], e_eb + r[3]};
            e_lcv = e_lcv + lcv_hit(r[4], r[6] && !r[4], m[0]);
            e_crc = e_crc + r[5];
            @(posedge clk_i);
         end
         {ps, mf, fas, eb, bv, ez, ce, alm} <= '0;
         @(posedge clk_i);
         rchk(EPM_PAGE_MON, EPM_A_PRBS_ERR, e_ps);
         rchk(EPM_PAGE_MON, EPM_A_PRBS_MF, e_mf);
         rchk(EPM_PAGE_MON, EPM_A_EFAS, e_fas);
         rchk(EPM_PAGE_MON, EPM_A_EBIT_HI, {6'h00, e_eb[9:8]});
         rchk(EPM_PAGE_MON, EPM_A_EBIT_LO, e_eb[7:0]);
         rchk(EPM_PAGE_MON, EPM_A_LCV_HI, e_lcv[15:8]);
         rchk(EPM_PAGE_MON, EPM_A_LCV_LO, e_lcv[7:0]);
         rchk(EPM_PAGE_MON, EPM_A_CRC_HI, e_crc[15:8]);
         rchk(EPM_PAGE_MON, EPM_A_CRC_LO, e_crc[7:0]);
         rchk(EPM_PAGE_MON, EPM_A_ALARM, e_alm);
         e_alm = 8'h00;
      end
      chk({7'h00, zen}, 8'h01);
      $display("test random counts done");
      // Write loads the PRBS count and clears the multiframe count; read-only ignores it
      r = $urandom;
      u_epm_host.wr_reg(EPM_PAGE_MON, EPM_A_PRBS_ERR, r[7:0]);
      rchk(EPM_PAGE_MON, EPM_A_PRBS_ERR, r[7:0]);
      rchk(EPM_PAGE_MON, EPM_A_PRBS_MF, 8'h00);
      u_epm_host.wr_reg(EPM_PAGE_MON, EPM_A_EFAS, ~e_fas);
      rchk(EPM_PAGE_MON, EPM_A_EFAS, e_fas);
      // One multiframe, then a write with the multiframe read right behind it
      mf <= 1'b1;
      @(posedge clk_i);
      mf <= 1'b0;
      rchk(EPM_PAGE_MON, EPM_A_PRBS_MF, 8'h01);
      u_epm_host.wr_reg(EPM_PAGE_MON, EPM_A_PRBS_ERR, 8'h00);
      rchk(EPM_PAGE_MON, EPM_A_PRBS_MF, 8'h00);
      $display("test prbs write done");
      // Each alarm bit alone, then a back-to-back read sees it cleared
      for (int b = 0; b < 7; b++)
      begin
         alm <= 7'(1 << b);
         @(posedge clk_i);
         alm <= 7'h00;
         u_epm_host.rd_reg(EPM_PAGE_MON, EPM_A_ALARM, 2, d0, d1);
         chk(d0, 8'(2 << b));
         chk(d1, 8'h00);
      end
      $display("test alarm latch done");
      // Event words and converter readback
      r = $urandom;
      {evt0, evt1, line_peak, eq_peak} <= {r[7:0], ~r[7:0], r[12:8], r[23:16]};
      @(posedge clk_i);
      {evt0, evt1} <= 16'h0000;
      rchk(EPM_PAGE_MON, EPM_A_EVT0, r[7:0]);
      rchk(EPM_PAGE_MON, EPM_A_EVT1, ~r[7:0]);
      rchk(EPM_PAGE_MON, EPM_A_EVT0, 8'h00);
      rchk(EPM_PAGE_ANALOG, EPM_A_LPEAK, {3'h0, r[12:8]});
      rchk(EPM_PAGE_ANALOG, EPM_A_EPEAK, r[23:16]);
      rchk(EPM_PAGE_ANALOG, EPM_A_ID, ID);
      $display("test event words and readback done");
      complete_run();
   end
endmodule : epm_counters_tb
